// file: design/cabe_pkg.sv
package cabe_pkg;

    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] LOCAL_FLAGS_RESET = 8'h00;

    // I/O space: six address bits, bit set/clear limited to the low range
    localparam int IO_ADDR_W = 6;
    localparam logic [5:0] IO_LOW_MAX = 6'h1f;
    localparam logic [5:0] LOCAL_FLAG_ADDR = 6'h02;

    // Program counter steps
    localparam int PC_W_DEFAULT = 12;
    localparam int OFFSET_W = 7;
    localparam int STEP_SEQ = 1;
    localparam int STEP_SKIP_ONE_WORD = 2;
    localparam int STEP_SKIP_TWO_WORD = 3;
    localparam int STEP_BRANCH = 1;

    typedef enum logic [3:0] {
        OP_ADD_CARRY,
        OP_WORD_IMM_ADD,
        OP_CMP_IMM,
        OP_REG_BIT_SKIP,
        OP_IO_BIT_SKIP,
        OP_BRANCH_SET,
        OP_BRANCH_CLEAR,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_IO_WRITE
    } cabe_op_e;

    typedef enum logic {
        ALU_ADD,
        ALU_SUB
    } cabe_alu_op_e;

endpackage

// file: design/cabe_alu_if.sv
`timescale 1ns/1ps
interface cabe_alu_if;
    import cabe_pkg::*;

    cabe_alu_op_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic [7:0] res;
    logic c;
    logic h;
    logic v;
    logic n;
    logic z;

    modport core (output op, output a, output b, output cin,
                  input res, input c, input h, input v, input n, input z);
    modport alu (input op, input a, input b, input cin,
                 output res, output c, output h, output v, output n, output z);
endinterface

// file: design/cabe_alu.sv
`timescale 1ns/1ps
module cabe_alu (
    cabe_alu_if.alu bus
);
    import cabe_pkg::*;

    // Borrow or carry out of a bit position, from operands and result
    function automatic logic carry_at(input logic a, input logic b, input logic r,
                                      input logic is_sub);
        if (is_sub) begin
            carry_at = (~a & b) | (b & r) | (r & ~a);
        end else begin
            carry_at = (a & b) | (b & ~r) | (~r & a);
        end
    endfunction

    // Eight-bit add or subtract with carry in and C, H, V, N, Z flags
    always_comb begin
        logic is_sub;
        is_sub = (bus.op == ALU_SUB);
        if (is_sub) begin
            bus.res = 8'(bus.a - bus.b - {7'h00, bus.cin});
        end else begin
            bus.res = 8'(bus.a + bus.b + {7'h00, bus.cin});
        end
        bus.c = carry_at(bus.a[7], bus.b[7], bus.res[7], is_sub);
        bus.h = carry_at(bus.a[3], bus.b[3], bus.res[3], is_sub);
        if (is_sub) begin
            bus.v = (bus.a[7] & ~bus.b[7] & ~bus.res[7]) | (~bus.a[7] & bus.b[7] & bus.res[7]);
        end else begin
            bus.v = (bus.a[7] & bus.b[7] & ~bus.res[7]) | (~bus.a[7] & ~bus.b[7] & bus.res[7]);
        end
        bus.n = bus.res[7];
        bus.z = (bus.res == 8'h00);
    end

endmodule

// file: design/cabe_exec.sv
`timescale 1ns/1ps
// Summary of operation
// - Add with carry, five flags, one clock
// - Word immediate add, five flags, two clocks
// - Compare immediate: flags only, one clock
// - Register bit clear skips by two/three
// - I/O bit clear skips by two/three
// - Branch when chosen flag set
// - Branch when chosen flag clear
// - Writing one clears local event flags
// - Bit set/clear rewrites whole register
// - Bit set/clear only addresses 0 to 31
module cabe_exec #(
    parameter int PC_W = cabe_pkg::PC_W_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire cabe_pkg::cabe_op_e i_op,
    input wire logic [7:0] i_rd_val,
    input wire logic [7:0] i_rr_val,
    input wire logic [7:0] i_imm,
    input wire logic [2:0] i_bit,
    input wire logic [cabe_pkg::OFFSET_W-1:0] i_offset,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic i_next_two_word,
    input wire logic [cabe_pkg::IO_ADDR_W-1:0] i_io_addr,
    input wire logic [7:0] i_io_rdata,
    input wire logic [7:0] i_evt_set,
    output logic o_done,
    output logic o_refused,
    output logic o_wr_en,
    output logic o_wr_hi,
    output logic [7:0] o_wr_data,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_next,
    output logic o_io_we,
    output logic [cabe_pkg::IO_ADDR_W-1:0] o_io_addr,
    output logic [7:0] o_io_wdata,
    output logic [7:0] o_status,
    output logic [7:0] o_local_flags
);
    import cabe_pkg::*;

    typedef enum {ST_IDLE, ST_WORD_HI} cabe_state_e;

    // The offset sign extension needs room for the full offset
    if (PC_W < OFFSET_W + 1) begin : g_pc_w_check
        $error("PC_W too small for branch offset");
    end

    cabe_alu_if alu_bus ();

    cabe_alu u_alu (
        .bus(alu_bus.alu)
    );

    cabe_state_e state, next_state;
    logic [7:0] status, next_status;
    logic [7:0] local_flags, next_local_flags;
    logic [7:0] word_hi, next_word_hi;
    logic word_c, next_word_c;
    logic word_lo_zero, next_word_lo_zero;
    logic done, next_done;
    logic refused, next_refused;
    logic wr_en, next_wr_en;
    logic wr_hi, next_wr_hi;
    logic [7:0] wr_data, next_wr_data;
    logic [PC_W-1:0] pc_next, next_pc_next;
    logic io_we, next_io_we;
    logic [IO_ADDR_W-1:0] io_addr, next_io_addr;
    logic [7:0] io_wdata, next_io_wdata;

    // PC step as a PC-wide value
    function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc, input int step);
        pc_step = PC_W'(pc + PC_W'(step));
    endfunction

    logic [7:0] io_val;
    logic [PC_W-1:0] offset_ext;
    logic [PC_W-1:0] pc_skip;
    logic [7:0] local_clear;
    logic w_res15;

    // Local flags are read in place of the outside register at their address
    assign io_val = (i_io_addr == LOCAL_FLAG_ADDR) ? local_flags : i_io_rdata;
    assign offset_ext = {{(PC_W - OFFSET_W){i_offset[OFFSET_W-1]}}, i_offset};
    assign pc_skip = i_next_two_word ? pc_step(i_pc, STEP_SKIP_TWO_WORD)
                                     : pc_step(i_pc, STEP_SKIP_ONE_WORD);
    assign w_res15 = alu_bus.res[7];
    assign o_ready = (state == ST_IDLE);

    // ALU operand steering; the word high byte only ripples the low carry
    always_comb begin
        alu_bus.op = ALU_ADD;
        alu_bus.a = i_rd_val;
        alu_bus.b = i_rr_val;
        alu_bus.cin = status[FLAG_C];
        if (state == ST_WORD_HI) begin
            alu_bus.a = word_hi;
            alu_bus.b = 8'h00;
            alu_bus.cin = word_c;
        end else if (i_op == OP_CMP_IMM) begin
            alu_bus.op = ALU_SUB;
            alu_bus.b = i_imm;
            alu_bus.cin = 1'b0;
        end else if (i_op == OP_WORD_IMM_ADD) begin
            alu_bus.b = i_imm;
            alu_bus.cin = 1'b0;
        end
    end

    // Instruction sequencing, flags, program counter and I/O writes
    always_comb begin
        next_state = state;
        next_status = status;
        next_word_hi = word_hi;
        next_word_c = word_c;
        next_word_lo_zero = word_lo_zero;
        next_done = 1'b0;
        next_refused = 1'b0;
        next_wr_en = 1'b0;
        next_wr_hi = 1'b0;
        next_wr_data = wr_data;
        next_pc_next = pc_next;
        next_io_we = 1'b0;
        next_io_addr = io_addr;
        next_io_wdata = io_wdata;
        local_clear = 8'h00;
        if (state == ST_WORD_HI) begin
            // Second clock: high byte and whole-word flags
            next_wr_en = 1'b1;
            next_wr_hi = 1'b1;
            next_wr_data = alu_bus.res;
            next_status[FLAG_N] = w_res15;
            next_status[FLAG_V] = ~word_hi[7] & w_res15;
            next_status[FLAG_C] = ~w_res15 & word_hi[7];
            next_status[FLAG_Z] = word_lo_zero & alu_bus.z;
            next_status[FLAG_S] = w_res15 ^ (~word_hi[7] & w_res15);
            next_pc_next = pc_step(pc_next, 0);
            next_done = 1'b1;
            next_state = ST_IDLE;
        end else if (i_valid) begin
            next_done = 1'b1;
            next_pc_next = pc_step(i_pc, STEP_SEQ);
            case (i_op)
                OP_ADD_CARRY: begin
                    next_wr_en = 1'b1;
                    next_wr_data = alu_bus.res;
                    next_status[FLAG_Z] = alu_bus.z;
                    next_status[FLAG_C] = alu_bus.c;
                    next_status[FLAG_N] = alu_bus.n;
                    next_status[FLAG_V] = alu_bus.v;
                    next_status[FLAG_H] = alu_bus.h;
                end
                OP_WORD_IMM_ADD: begin
                    // First clock: low byte, keep carry for the high byte
                    next_done = 1'b0;
                    next_wr_en = 1'b1;
                    next_wr_data = alu_bus.res;
                    next_word_hi = i_rr_val;
                    next_word_c = alu_bus.c;
                    next_word_lo_zero = alu_bus.z;
                    next_state = ST_WORD_HI;
                end
                OP_CMP_IMM: begin
                    next_status[FLAG_Z] = alu_bus.z;
                    next_status[FLAG_C] = alu_bus.c;
                    next_status[FLAG_N] = alu_bus.n;
                    next_status[FLAG_V] = alu_bus.v;
                    next_status[FLAG_H] = alu_bus.h;
                end
                OP_REG_BIT_SKIP: begin
                    if (!i_rd_val[i_bit]) begin
                        next_pc_next = pc_skip;
                    end
                end
                OP_IO_BIT_SKIP: begin
                    if (!io_val[i_bit]) begin
                        next_pc_next = pc_skip;
                    end
                end
                OP_BRANCH_SET: begin
                    if (status[i_bit]) begin
                        next_pc_next = PC_W'(i_pc + offset_ext + PC_W'(STEP_BRANCH));
                    end
                end
                OP_BRANCH_CLEAR: begin
                    if (!status[i_bit]) begin
                        next_pc_next = PC_W'(i_pc + offset_ext + PC_W'(STEP_BRANCH));
                    end
                end
                OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                    if (i_io_addr > IO_LOW_MAX) begin
                        // Refusal still moves the PC on, but never counts as done
                        next_done = 1'b0;
                        next_refused = 1'b1;
                    end else begin
                        // Whole register goes back, so set flags read as one get cleared
                        next_io_wdata = io_val;
                        next_io_wdata[i_bit] = (i_op == OP_IO_BIT_SET);
                        next_io_addr = i_io_addr;
                        next_io_we = (i_io_addr != LOCAL_FLAG_ADDR);
                        if (i_io_addr == LOCAL_FLAG_ADDR) begin
                            local_clear = next_io_wdata;
                        end
                    end
                end
                OP_IO_WRITE: begin
                    next_io_wdata = i_rd_val;
                    next_io_addr = i_io_addr;
                    next_io_we = (i_io_addr != LOCAL_FLAG_ADDR);
                    if (i_io_addr == LOCAL_FLAG_ADDR) begin
                        local_clear = i_rd_val;
                    end
                end
                default: begin
                    next_done = 1'b0;
                    next_refused = 1'b1;
                end
            endcase
        end
        // Write one clears, write zero keeps; a new event wins over a clear
        next_local_flags = (local_flags & ~local_clear) | i_evt_set;
    end

    // Register stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            status <= STATUS_RESET;
            local_flags <= LOCAL_FLAGS_RESET;
            word_hi <= 8'h00;
            word_c <= 1'b0;
            word_lo_zero <= 1'b0;
            done <= 1'b0;
            refused <= 1'b0;
            wr_en <= 1'b0;
            wr_hi <= 1'b0;
            wr_data <= 8'h00;
            pc_next <= '0;
            io_we <= 1'b0;
            io_addr <= '0;
            io_wdata <= 8'h00;
        end else begin
            state <= next_state;
            status <= next_status;
            local_flags <= next_local_flags;
            word_hi <= next_word_hi;
            word_c <= next_word_c;
            word_lo_zero <= next_word_lo_zero;
            done <= next_done;
            refused <= next_refused;
            wr_en <= next_wr_en;
            wr_hi <= next_wr_hi;
            wr_data <= next_wr_data;
            pc_next <= next_pc_next;
            io_we <= next_io_we;
            io_addr <= next_io_addr;
            io_wdata <= next_io_wdata;
        end
    end

    // Registered outputs
    assign o_done = done;
    assign o_refused = refused;
    assign o_wr_en = wr_en;
    assign o_wr_hi = wr_hi;
    assign o_wr_data = wr_data;
    assign o_pc_load = done | refused;
    assign o_pc_next = pc_next;
    assign o_io_we = io_we;
    assign o_io_addr = io_addr;
    assign o_io_wdata = io_wdata;
    assign o_status = status;
    assign o_local_flags = local_flags;

endmodule

// file: bench/cabe_exec_monitor.sv
`timescale 1ns/1ps
module cabe_exec_monitor #(
    parameter int PC_W = 12
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic o_ready,
    input wire cabe_pkg::cabe_op_e i_op,
    input wire logic [7:0] i_rd_val,
    input wire logic [7:0] i_rr_val,
    input wire logic [2:0] i_bit,
    input wire logic [cabe_pkg::OFFSET_W-1:0] i_offset,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic i_next_two_word,
    input wire logic [cabe_pkg::IO_ADDR_W-1:0] i_io_addr,
    input wire logic [7:0] i_io_rdata,
    input wire logic [7:0] i_evt_set,
    input wire logic o_done,
    input wire logic o_refused,
    input wire logic o_wr_en,
    input wire logic o_wr_hi,
    input wire logic [7:0] o_wr_data,
    input wire logic o_pc_load,
    input wire logic [PC_W-1:0] o_pc_next,
    input wire logic o_io_we,
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_local_flags
);
    import cabe_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // An instruction is taken on this edge
    logic take;
    assign take = i_valid && o_ready;

    chk_branch_tgt: assert property (take && i_op == OP_BRANCH_SET && o_status[i_bit]
        |=> o_pc_load && o_pc_next == PC_W'($past(i_pc) + PC_W'($signed($past(i_offset))) + 1))
        else $error("taken branch target wrong");
    chk_adc_sum: assert property (take && i_op == OP_ADD_CARRY |=> o_done && o_wr_en
        && o_wr_data == 8'($past(i_rd_val) + $past(i_rr_val) + $past(o_status[0])))
        else $error("add with carry result wrong");
    chk_word_two: assert property (take && i_op == OP_WORD_IMM_ADD |=>
        !o_ready && o_wr_en && !o_wr_hi && !o_done ##1 o_done && o_wr_en && o_wr_hi)
        else $error("word add not two clocks");
    chk_cmp_nowr: assert property (take && i_op == OP_CMP_IMM |=> o_done && !o_wr_en)
        else $error("compare wrote a register");
    chk_skip_io: assert property (take && i_op == OP_IO_BIT_SKIP
        && i_io_addr != LOCAL_FLAG_ADDR && !i_io_rdata[i_bit] && !i_next_two_word
        |=> o_pc_next == PC_W'($past(i_pc) + 2) && $stable(o_status))
        else $error("io skip step wrong");
    chk_flags_kept: assert property (take && (i_op inside {OP_REG_BIT_SKIP,
        OP_BRANCH_SET, OP_BRANCH_CLEAR}) |=> $stable(o_status))
        else $error("flags moved on skip or branch");
    chk_refuse_hi: assert property (take && (i_op inside {OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR}) && i_io_addr > IO_LOW_MAX |=> o_refused && !o_done && !o_io_we)
        else $error("high bit set or clear not refused");
    chk_w1c_local: assert property (take && i_op == OP_IO_WRITE
        && i_io_addr == LOCAL_FLAG_ADDR |=> !o_io_we
        && (o_local_flags & $past(i_rd_val) & ~$past(i_evt_set)) == 8'h00)
        else $error("written ones did not clear flags");

    cov_word: cover property (take && i_op == OP_WORD_IMM_ADD);
    cov_refused: cover property (o_refused);
    cov_local: cover property (take && i_io_addr == LOCAL_FLAG_ADDR);
endmodule

bind cabe_exec cabe_exec_monitor #(.PC_W(PC_W)) cabe_exec_monitor_inst (.*);

// file: bench/cabe_io_model.sv
`timescale 1ns/1ps
module cabe_io_model (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [5:0] i_rd_addr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [64];
    // Known pattern so an unwritten place never reads as unknown
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end
    // Plain always: the bench also preloads places directly
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end
    assign o_rdata = mem[i_rd_addr]; // Same-cycle read
endmodule

// file: bench/core_arith_branch_exec_bench.sv
`timescale 1ns/1ps
module core_arith_branch_exec_bench;
    import cabe_pkg::*;
    localparam int PC_W = 12;
    logic i_clk, i_rst, i_valid, i_next_two_word;
    cabe_op_e i_op;
    logic [7:0] i_rd_val, i_rr_val, i_imm, i_io_rdata, i_evt_set;
    logic [2:0] i_bit;
    logic [OFFSET_W-1:0] i_offset, nx_off;
    logic [PC_W-1:0] i_pc, o_pc_next, pc;
    logic [IO_ADDR_W-1:0] i_io_addr, o_io_addr, nx_addr;
    logic o_ready, o_done, o_refused, o_wr_en, o_wr_hi, o_pc_load, o_io_we, nx_two;
    logic [7:0] o_wr_data, o_io_wdata, o_status, o_local_flags;
    int miscompares = 0;
    int n_compared = 0;

    cabe_exec #(.PC_W(PC_W)) cabe_exec_inst (.*);
    cabe_io_model cabe_io_model_inst (.i_clk(i_clk), .i_we(o_io_we), .i_addr(o_io_addr),
        .i_wdata(o_io_wdata), .i_rd_addr(i_io_addr), .o_rdata(i_io_rdata));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Drive at an edge, taken at the next, looked at mid-cycle while pulses stand
    task automatic issue(input cabe_op_e op, input logic [7:0] a = 8'h00,
        input logic [7:0] b = 8'h00, input logic [7:0] k = 8'h00, input logic [2:0] bt = 3'h0);
        @(posedge i_clk);
        i_op <= op;
        i_rd_val <= a;
        i_rr_val <= b;
        i_imm <= k;
        i_bit <= bt;
        i_pc <= pc;
        i_offset <= nx_off;
        i_next_two_word <= nx_two;
        i_io_addr <= nx_addr;
        i_valid <= 1'b1;
        @(posedge i_clk);
        i_valid <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic t_arith();
        pc = 12'h010;
        issue(OP_ADD_CARRY, 8'hff, 8'h01);
        chk({o_done, o_wr_en, o_wr_data, o_pc_next}, {2'b11, 8'h00, 12'h011});
        chk(o_status, 8'h23);
        issue(OP_ADD_CARRY, 8'h7f, 8'h00);
        chk({o_wr_data, o_status}, {8'h80, 8'h2c});
        issue(OP_WORD_IMM_ADD, 8'hf0, 8'hff, 8'h20);
        chk({o_ready, o_wr_en, o_wr_hi, o_done, o_wr_data}, {4'b0100, 8'h10});
        @(negedge i_clk);
        chk({o_ready, o_wr_en, o_wr_hi, o_done, o_wr_data}, {4'b1111, 8'h00});
        chk(o_status, 8'h21);
        issue(OP_CMP_IMM, 8'h10, 8'h00, 8'h20);
        chk({o_done, o_wr_en, o_status}, {2'b10, 8'h05});
    endtask

    task automatic t_skip_branch();
        pc = 12'h040;
        nx_two = 1'b1;
        issue(OP_REG_BIT_SKIP, 8'hfb, 8'h00, 8'h00, 3'h2);
        chk({o_pc_next, o_status}, {12'h043, 8'h05});
        issue(OP_REG_BIT_SKIP, 8'hfb, 8'h00, 8'h00, 3'h3);
        chk(o_pc_next, 12'h041);
        nx_two = 1'b0;
        nx_addr = 6'h10;
        cabe_io_model_inst.mem[16] = 8'hf7;
        issue(OP_IO_BIT_SKIP, 8'h00, 8'h00, 8'h00, 3'h3);
        chk(o_pc_next, 12'h042);
        pc = 12'h100;
        nx_off = 7'h7e;
        issue(OP_BRANCH_SET);
        chk({o_pc_next, o_status}, {12'h0ff, 8'h05});
        issue(OP_BRANCH_CLEAR);
        chk(o_pc_next, 12'h101);
        nx_off = 7'h05;
        issue(OP_BRANCH_CLEAR, 8'h00, 8'h00, 8'h00, 3'h1);
        chk({o_pc_next, o_status}, {12'h106, 8'h05});
    endtask

    // Outside addresses in the low mapped range, plus one just above it that is refused
    task automatic t_io_bits();
        nx_addr = 6'h05;
        cabe_io_model_inst.mem[5] = 8'h81;
        issue(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 3'h1);
        chk({o_io_we, o_io_addr, o_io_wdata}, {1'b1, 6'h05, 8'h83});
        issue(OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 3'h7);
        chk({o_io_we, o_io_wdata}, {1'b1, 8'h03});
        nx_addr = 6'h20;
        issue(OP_IO_BIT_SET);
        chk({o_refused, o_done, o_io_we, o_pc_load}, 4'b1001);
        nx_addr = 6'h1f;
        issue(OP_IO_BIT_SET);
        chk({o_refused, o_io_we, o_io_wdata}, {2'b01, 8'hbb});
    endtask

    task automatic t_local_flags();
        nx_addr = LOCAL_FLAG_ADDR;
        @(posedge i_clk);
        i_evt_set <= 8'h0c;
        @(posedge i_clk);
        i_evt_set <= 8'h00;
        @(negedge i_clk);
        chk(o_local_flags, 8'h0c);
        issue(OP_IO_BIT_SET);
        chk({o_io_we, o_local_flags}, {1'b0, 8'h00});
        @(posedge i_clk);
        i_evt_set <= 8'h0c;
        @(posedge i_clk);
        i_evt_set <= 8'h00;
        issue(OP_IO_WRITE, 8'h04);
        chk(o_local_flags, 8'h08);
        issue(OP_IO_WRITE, 8'h00);
        chk(o_local_flags, 8'h08);
    endtask

    initial begin
        i_rst = 1'b1;
        i_valid = 1'b0;
        i_op = OP_ADD_CARRY;
        {i_rd_val, i_rr_val, i_imm, i_evt_set} = 32'h0;
        {i_bit, i_offset, i_pc, i_next_two_word, i_io_addr} = '0;
        {nx_off, nx_two, nx_addr, pc} = '0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk({o_ready, o_done, o_status, o_local_flags}, {2'b10, 16'h0000});
        t_arith();
        t_skip_branch();
        t_io_bits();
        t_local_flags();
        report_and_stop();
    end

    // The whole sequence needs well under a microsecond
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule
